// ---- src/fxcor_fifo.sv ----
// Parameterised FIFO with a registered output stage.
`timescale 1ns/10ps
`default_nettype none
module fxcor_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	output logic                  outValid,
	output logic [WIDTH-1:0]      outData,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [0:DEPTH-1]; // Word storage.
	logic [AW-1:0]    wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
	logic [AW:0]      count_ff, nxt_count;
	logic             inReady_ff, nxt_inReady, outValid_ff, nxt_outValid;
	logic [WIDTH-1:0] outData_ff, nxt_outData;
	logic             push, pop;
	// ============================================================
	// Pointer and count update; output stage refills when drained.
	always_comb begin
		push = inValid && inReady_ff;
		pop = (count_ff != '0) && (!outValid_ff || outReady);
		nxt_wrPtr = push ? wrPtr_ff + 1'b1 : wrPtr_ff;
		nxt_rdPtr = pop ? rdPtr_ff + 1'b1 : rdPtr_ff;
		nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
		nxt_inReady = nxt_count < (AW+1)'(DEPTH);
		nxt_outValid = pop ? 1'b1 : (outValid_ff && !outReady);
		nxt_outData = pop ? mem[rdPtr_ff] : outData_ff;
	end
	// Registers only.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
			inReady_ff <= 1'b0;
			outValid_ff <= 1'b0;
			outData_ff <= '0;
		end else begin
			wrPtr_ff <= nxt_wrPtr;
			rdPtr_ff <= nxt_rdPtr;
			count_ff <= nxt_count;
			inReady_ff <= nxt_inReady;
			outValid_ff <= nxt_outValid;
			outData_ff <= nxt_outData;
		end
	end
	// Storage has no reset; only written words are ever read.
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wrPtr_ff] <= inData;
		end
	end
	assign inReady = inReady_ff;
	assign outValid = outValid_ff;
	assign outData = outData_ff;
endmodule
`default_nettype wire

// ---- src/fxcor_loader.sv ----
// Byte-serial coefficient block parser and word assembler.
`timescale 1ns/10ps
`default_nettype none
module fxcor_loader
	import fxcor_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       loadStart,
	input  wire logic       byteValid,
	input  wire logic [7:0] byteData,
	output logic            byteReady,
	output logic            coefWrEn,
	output logic [3:0]      coefSet,
	output logic [5:0]      coefTap,
	output logic [15:0]     coefWord,
	output logic [3:0]      setCount,
	output logic [5:0]      tapCount,
	output logic            loadDone,
	output logic            loadError
);
	// Set counts that a block may announce.
	function automatic logic legalSets(input logic [7:0] v);
		return v == `FXC_SETS_1 || v == `FXC_SETS_2 ||
			v == `FXC_SETS_4 || v == `FXC_SETS_9;
	endfunction
	// Tap counts that a block may announce.
	function automatic logic legalTaps(input logic [7:0] v);
		return v == `FXC_TAPS_2 || v == `FXC_TAPS_7 ||
			v == `FXC_TAPS_13 || v == `FXC_TAPS_63;
	endfunction
	fxcor_load_e state_ff, nxt_state;
	logic [1:0]  idx_ff, nxt_idx;     // Header byte offset.
	logic [7:0]  low_ff, nxt_low;     // Held low byte.
	logic        haveLow_ff, nxt_haveLow;
	logic [3:0]  set_ff, nxt_set, sets_ff, nxt_sets, wrSet_ff, nxt_wrSet;
	logic [5:0]  tap_ff, nxt_tap, taps_ff, nxt_taps, wrTap_ff, nxt_wrTap;
	logic [15:0] word_ff, nxt_word;
	logic        wrEn_ff, nxt_wrEn, ready_ff, nxt_ready;
	logic        done_ff, nxt_done, err_ff, nxt_err, take;
	// ============================================================
	// Parser; a new load request restarts from offset zero.
	always_comb begin
		take = byteValid && ready_ff;
		nxt_state = state_ff;
		nxt_idx = idx_ff;
		nxt_low = low_ff;
		nxt_haveLow = haveLow_ff;
		nxt_set = set_ff;
		nxt_tap = tap_ff;
		nxt_sets = sets_ff;
		nxt_taps = taps_ff;
		nxt_wrSet = wrSet_ff;
		nxt_wrTap = wrTap_ff;
		nxt_word = word_ff;
		nxt_wrEn = 1'b0;
		if (loadStart) begin
			nxt_state = LD_HDR;
			nxt_idx = `FXC_OFS_FMT_LO;
			nxt_haveLow = 1'b0;
			nxt_set = '0;
			nxt_tap = '0;
		end else if (take) begin
			case (state_ff)
				LD_HDR: begin
					nxt_idx = idx_ff + 2'h1;
					case (idx_ff)
						`FXC_OFS_FMT_LO, `FXC_OFS_FMT_HI: begin
							if (byteData != `FXC_FMT_VALUE) nxt_state = LD_ERR;
						end
						`FXC_OFS_SETS: begin
							if (legalSets(byteData)) nxt_sets = byteData[3:0];
							else nxt_state = LD_ERR;
						end
						default: begin
							if (legalTaps(byteData)) begin
								nxt_taps = byteData[5:0];
								nxt_state = LD_COEF;
							end else begin
								nxt_state = LD_ERR;
							end
						end
					endcase
				end
				LD_COEF: begin
					if (!haveLow_ff) begin
						nxt_low = byteData;
						nxt_haveLow = 1'b1;
					end else begin
						nxt_wrEn = 1'b1;
						nxt_word = {byteData, low_ff};
						nxt_wrSet = set_ff;
						nxt_wrTap = tap_ff;
						nxt_haveLow = 1'b0;
						if (tap_ff == taps_ff - 6'h01) begin
							nxt_tap = '0;
							nxt_set = set_ff + 4'h1;
							if (set_ff == sets_ff - 4'h1) nxt_state = LD_DONE;
						end else begin
							nxt_tap = tap_ff + 6'h01;
						end
					end
				end
				default: begin
				end
			endcase
		end
		nxt_ready = (nxt_state == LD_HDR) || (nxt_state == LD_COEF);
		nxt_done = nxt_state == LD_DONE;
		nxt_err = nxt_state == LD_ERR;
	end
	// Registers only.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_ff <= LD_IDLE;
			idx_ff <= '0;
			low_ff <= '0;
			haveLow_ff <= 1'b0;
			set_ff <= '0;
			tap_ff <= '0;
			sets_ff <= 4'h1;
			taps_ff <= 6'h02;
			wrSet_ff <= '0;
			wrTap_ff <= '0;
			word_ff <= '0;
			wrEn_ff <= 1'b0;
			ready_ff <= 1'b0;
			done_ff <= 1'b0;
			err_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			idx_ff <= nxt_idx;
			low_ff <= nxt_low;
			haveLow_ff <= nxt_haveLow;
			set_ff <= nxt_set;
			tap_ff <= nxt_tap;
			sets_ff <= nxt_sets;
			taps_ff <= nxt_taps;
			wrSet_ff <= nxt_wrSet;
			wrTap_ff <= nxt_wrTap;
			word_ff <= nxt_word;
			wrEn_ff <= nxt_wrEn;
			ready_ff <= nxt_ready;
			done_ff <= nxt_done;
			err_ff <= nxt_err;
		end
	end
	assign byteReady = ready_ff;
	assign coefWrEn = wrEn_ff;
	assign coefSet = wrSet_ff;
	assign coefTap = wrTap_ff;
	assign coefWord = word_ff;
	assign setCount = sets_ff;
	assign tapCount = taps_ff;
	assign loadDone = done_ff;
	assign loadError = err_ff;
	// ============================================================
	// Checks.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	AST_FMT_WORD: assert property (state_ff == LD_HDR && take && !loadStart &&
		idx_ff <= `FXC_OFS_FMT_HI && byteData != `FXC_FMT_VALUE |=> err_ff)
		else $error("nonzero format word not refused");
	AST_LITTLE_END: assert property (coefWrEn |->
		coefWord[15:8] == $past(byteData) && coefWord[7:0] == $past(low_ff))
		else $error("coefficient bytes assembled in wrong order");
	AST_SETS_LEGAL: assert property (loadDone |-> legalSets({4'h0, setCount}))
		else $error("illegal set count accepted");
	AST_TAPS_LEGAL: assert property (loadDone |-> legalTaps({2'h0, tapCount}))
		else $error("illegal tap count accepted");
	AST_FIRST_COEF: assert property (state_ff == LD_HDR && take && !loadStart &&
		idx_ff == `FXC_OFS_TAPS && legalTaps(byteData) |=>
		state_ff == LD_COEF && set_ff == 4'h0 && tap_ff == 6'h00 && !haveLow_ff)
		else $error("coefficients do not start after header");
endmodule
`default_nettype wire

// ---- src/fxcor_params.svh ----
// Constants shared by the flash interleave correction filter.
`ifndef FXCOR_PARAMS_SVH
`define FXCOR_PARAMS_SVH
// ============================================================
// Data widths.
`define FXC_SAMPLE_W   8
`define FXC_COEF_W     16
`define FXC_OUT_W      16
`define FXC_ACC_W      40
`define FXC_PROD_W     32
// ============================================================
// Table sizes.
`define FXC_MAX_SETS   9
`define FXC_MAX_TAPS   63
`define FXC_FIFO_DEPTH 8
// ============================================================
// Coefficient block layout and legal header values.
`define FXC_FMT_VALUE  8'h00
`define FXC_OFS_FMT_LO 2'h0
`define FXC_OFS_FMT_HI 2'h1
`define FXC_OFS_SETS   2'h2
`define FXC_OFS_TAPS   2'h3
`define FXC_SETS_1     8'h01
`define FXC_SETS_2     8'h02
`define FXC_SETS_4     8'h04
`define FXC_SETS_9     8'h09
`define FXC_TAPS_2     8'h02
`define FXC_TAPS_7     8'h07
`define FXC_TAPS_13    8'h0d
`define FXC_TAPS_63    8'h3f
// ============================================================
// Filter arithmetic.
`define FXC_BW_SET     4'h8
`define FXC_FLASH_MASK 4'h7
`define FXC_SHIFT1     6
`define FXC_SHIFT2     14
`define FXC_HIST_FULL  6'h3f
`define FXC_ACC_MAX    40'sh00_0000_7fff
`define FXC_ACC_MIN    40'shff_ffff_8000
`define FXC_OUT_MAX    16'h7fff
`define FXC_OUT_MIN    16'h8000
`endif

// ---- src/fxcor_pkg.sv ----
// Types shared by the flash interleave correction filter.
`include "fxcor_params.svh"
package fxcor_pkg;
	// ============================================================
	// Filter sequencer states.
	typedef enum logic [5:0] {
		ST_IDLE   = 6'b000001,
		ST_MAC1   = 6'b000010,
		ST_SCALE1 = 6'b000100,
		ST_MAC2   = 6'b001000,
		ST_SCALE2 = 6'b010000,
		ST_EMIT   = 6'b100000
	} fxcor_state_e;
	// Coefficient loader states.
	typedef enum logic [4:0] {
		LD_IDLE = 5'b00001,
		LD_HDR  = 5'b00010,
		LD_COEF = 5'b00100,
		LD_DONE = 5'b01000,
		LD_ERR  = 5'b10000
	} fxcor_load_e;
endpackage

// ---- src/fxcor_top.sv ----
// Flash interleave correction FIR: loader, sequencer, MAC and output FIFO.
//
// Function
// - Output is sum of coefficient times delayed input.
// - First M-1 inputs are history only.
// - Newest sample's flash picks the coefficient set.
// - Input samples are signed 8-bit two's complement.
// - Coefficients are signed 16-bit, 4000 hex unity.
// - Coefficient words assembled low byte first.
// - Format word at offsets 0,1 must be zero.
// - Offset 2 holds set count: 1,2,4,9.
// - Offset 3 holds taps: 2,7,13,63.
// - Coefficient words follow contiguously from offset 4.
// - Tap count and stride follow sample rate mode.
// - One pre-combined filter, single pass per output below 2 GS/s.
// - Product sum scaled by 1/64 to 16 bits.
// - 2 GS/s record gets extra 63-tap filter.
`timescale 1ns/10ps
`default_nettype none
module fxcor_top
	import fxcor_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       loadStart,
	input  wire logic       coefByteValid,
	input  wire logic [7:0] coefByteData,
	output logic            coefByteReady,
	input  wire logic       sampleValid,
	input  wire logic [7:0] sampleData,
	input  wire logic [2:0] sampleFlash,
	output logic            sampleReady,
	output logic            outValid,
	output logic [15:0]     outData,
	input  wire logic       outReady,
	output logic            loadDone,
	output logic            loadError
);
	// ============================================================
	// Saturation of a scaled sum to the output width.
	function automatic logic [`FXC_OUT_W-1:0] sat16(
		input logic signed [`FXC_ACC_W-1:0] v);
		if (v > `FXC_ACC_MAX) return `FXC_OUT_MAX;
		else if (v < `FXC_ACC_MIN) return `FXC_OUT_MIN;
		else return v[`FXC_OUT_W-1:0];
	endfunction

	// Loader outputs.
	logic        coefWrEn;   // One coefficient word is ready.
	logic [3:0]  coefSet;    // Its set index.
	logic [5:0]  coefTap;    // Its tap index.
	logic [15:0] coefWord;   // The assembled word.
	logic [3:0]  setCount;   // Sets announced by the block.
	logic [5:0]  tapCount;   // Taps announced by the block.

	// Memories.
	logic signed [`FXC_COEF_W-1:0]   coefMem [0:`FXC_MAX_SETS-1]
		[0:`FXC_MAX_TAPS-1];
	logic signed [`FXC_SAMPLE_W-1:0] xHist [0:`FXC_MAX_TAPS-1]; // Newest at 0.
	logic signed [`FXC_OUT_W-1:0]    yHist [0:`FXC_MAX_TAPS-1]; // Stage one results.

	// Sequencer state.
	fxcor_state_e            state_ff, nxt_state;
	logic [5:0]              tap_ff, nxt_tap;       // Tap under work.
	logic [5:0]              xCount_ff, nxt_xCount; // Held input samples.
	logic [5:0]              yCount_ff, nxt_yCount; // Held stage one results.
	logic [3:0]              curSet_ff, nxt_curSet; // Selected set.
	logic signed [`FXC_ACC_W-1:0] acc_ff, nxt_acc;  // Running sum.
	logic [`FXC_OUT_W-1:0]   result_ff, nxt_result; // Word to emit.
	logic                    sReady_ff, nxt_sReady;

	// Decoded mode and datapath nets.
	logic                        mode2g;    // Nine sets: interleaved 2 GS/s.
	logic [5:0]                  taps1;     // Stage one length.
	logic [5:0]                  tapsLess;  // Stage one length minus one.
	logic [5:0]                  span1;     // Oldest sample distance.
	logic [5:0]                  histIdx;   // Sample read for this tap.
	logic [3:0]                  setMask;   // Flash index mask.
	logic signed [`FXC_COEF_W-1:0] mulA;    // Coefficient operand.
	logic signed [`FXC_OUT_W-1:0]  mulB;    // Data operand.
	logic signed [`FXC_PROD_W-1:0] product; // One tap product.
	logic                        take;      // Sample accepted now.
	logic                        fifoInReady;
	logic [5:0]                  xCountInc, yCountInc;

	// ============================================================
	// Coefficient block loader.
	fxcor_loader u_loader (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.loadStart (loadStart),
		.byteValid (coefByteValid),
		.byteData  (coefByteData),
		.byteReady (coefByteReady),
		.coefWrEn  (coefWrEn),
		.coefSet   (coefSet),
		.coefTap   (coefTap),
		.coefWord  (coefWord),
		.setCount  (setCount),
		.tapCount  (tapCount),
		.loadDone  (loadDone),
		.loadError (loadError)
	);

	// Coefficient table write; no reset, a load fills every entry read first unless nine sets carry under 63 taps.
	always_ff @(posedge sys_clk) begin
		if (coefWrEn) begin
			coefMem[coefSet][coefTap] <= coefWord;
		end
	end

	// ============================================================
	// Mode decode. At 2 GS/s the two channels alternate, so each
	// channel's taps sit two samples apart in the shared history.
	always_comb begin
		mode2g = {4'h0, setCount} == `FXC_SETS_9;
		taps1 = mode2g ? 6'(`FXC_TAPS_13) : tapCount;
		tapsLess = taps1 - 6'h01;
		span1 = mode2g ? {tapsLess[4:0], 1'b0} : tapsLess;
		histIdx = mode2g ? {tap_ff[4:0], 1'b0} : tap_ff;
		setMask = mode2g ? `FXC_FLASH_MASK : setCount - 4'h1;
		take = sampleValid && sReady_ff;
		xCountInc = (xCount_ff == `FXC_HIST_FULL) ? xCount_ff : xCount_ff + 6'h01;
		yCountInc = (yCount_ff == `FXC_HIST_FULL) ? yCount_ff : yCount_ff + 6'h01;
	end

	// ============================================================
	// Shared multiplier. Samples are sign extended, so 80 hex is the
	// most negative input; coefficients stay signed with 4000 hex as one.
	always_comb begin
		if (state_ff == ST_MAC2) begin
			mulA = coefMem[`FXC_BW_SET][tap_ff];
			mulB = yHist[tap_ff];
		end else begin
			mulA = coefMem[curSet_ff][tap_ff];
			mulB = 16'(xHist[histIdx]);
		end
		product = mulA * mulB;
	end

	// ============================================================
	// Sequencer. One sequential MAC per output trades throughput for
	// area: a new sample is taken only after the last result is queued.
	always_comb begin
		nxt_state = state_ff;
		nxt_tap = tap_ff;
		nxt_xCount = xCount_ff;
		nxt_yCount = yCount_ff;
		nxt_curSet = curSet_ff;
		nxt_acc = acc_ff;
		nxt_result = result_ff;
		if (loadStart) begin
			// New coefficients invalidate any half-built history.
			nxt_state = ST_IDLE;
			nxt_xCount = '0;
			nxt_yCount = '0;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (take) begin
						nxt_xCount = xCountInc;
						nxt_curSet = {1'b0, sampleFlash} & setMask;
						if (xCountInc > span1) begin
							nxt_state = ST_MAC1;
							nxt_tap = '0;
							nxt_acc = '0;
						end
					end
				end
				ST_MAC1: begin
					nxt_acc = acc_ff + `FXC_ACC_W'(product);
					if (tap_ff == tapsLess) nxt_state = ST_SCALE1;
					else nxt_tap = tap_ff + 6'h01;
				end
				ST_SCALE1: begin
					nxt_result = sat16(acc_ff >>> `FXC_SHIFT1);
					if (mode2g) begin
						nxt_yCount = yCountInc;
						if (yCountInc == `FXC_HIST_FULL) begin
							nxt_state = ST_MAC2;
							nxt_tap = '0;
							nxt_acc = '0;
						end else begin
							nxt_state = ST_IDLE;
						end
					end else begin
						nxt_state = ST_EMIT;
					end
				end
				ST_MAC2: begin
					nxt_acc = acc_ff + `FXC_ACC_W'(product);
					if (tap_ff == `FXC_HIST_FULL - 6'h01) nxt_state = ST_SCALE2;
					else nxt_tap = tap_ff + 6'h01;
				end
				ST_SCALE2: begin
					// Bandwidth taps use the same unity as flash taps.
					nxt_result = sat16(acc_ff >>> `FXC_SHIFT2);
					nxt_state = ST_EMIT;
				end
				ST_EMIT: begin
					if (fifoInReady) nxt_state = ST_IDLE;
				end
				default: begin
					nxt_state = ST_IDLE;
				end
			endcase
		end
		nxt_sReady = (nxt_state == ST_IDLE) && loadDone && !loadStart;
	end

	// Registers only.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			tap_ff <= '0;
			xCount_ff <= '0;
			yCount_ff <= '0;
			curSet_ff <= '0;
			acc_ff <= '0;
			result_ff <= '0;
			sReady_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			tap_ff <= nxt_tap;
			xCount_ff <= nxt_xCount;
			yCount_ff <= nxt_yCount;
			curSet_ff <= nxt_curSet;
			acc_ff <= nxt_acc;
			result_ff <= nxt_result;
			sReady_ff <= nxt_sReady;
		end
	end

	// ============================================================
	// History shift registers; stale entries are masked by the counts.
	always_ff @(posedge sys_clk) begin
		if (take && state_ff == ST_IDLE) begin
			xHist[0] <= sampleData;
			for (int i = 1; i < `FXC_MAX_TAPS; i++) begin
				xHist[i] <= xHist[i-1];
			end
		end
		if (state_ff == ST_SCALE1 && mode2g && !loadStart) begin
			yHist[0] <= nxt_result;
			for (int i = 1; i < `FXC_MAX_TAPS; i++) begin
				yHist[i] <= yHist[i-1];
			end
		end
	end

	// ============================================================
	// Output queue; a stalled consumer holds the sequencer in EMIT.
	fxcor_fifo #(
		.WIDTH (`FXC_OUT_W),
		.DEPTH (`FXC_FIFO_DEPTH)
	) u_fifo (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.inValid  (state_ff == ST_EMIT),
		.inData   (result_ff),
		.inReady  (fifoInReady),
		.outValid (outValid),
		.outData  (outData),
		.outReady (outReady)
	);
	assign sampleReady = sReady_ff;

	// ============================================================
	// Checks. The helper counts cycles spent in the first MAC.
	logic [5:0] macLen_ff;
	always_ff @(posedge sys_clk) begin
		if (rst || state_ff != ST_MAC1) macLen_ff <= '0;
		else macLen_ff <= macLen_ff + 6'h01;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence seqStart;
		state_ff == ST_IDLE && take && !loadStart && xCountInc > span1;
	endsequence
	sequence seqMacEnd;
		state_ff == ST_MAC1 && nxt_state == ST_SCALE1;
	endsequence
	AST_MAC_START: assert property (seqStart |=> state_ff == ST_MAC1 &&
		tap_ff == 6'h00 && acc_ff == '0)
		else $error("MAC did not start clean");
	AST_MAC_LEN: assert property (seqMacEnd |-> macLen_ff == tapsLess)
		else $error("MAC ran a wrong number of taps");
	AST_WARMUP: assert property ($rose(state_ff == ST_MAC1) |->
		xCount_ff > span1)
		else $error("output computed before history filled");
	AST_SET_SEL: assert property (seqStart |=>
		curSet_ff == ({1'b0, $past(sampleFlash)} & $past(setMask)))
		else $error("wrong coefficient set selected");
	AST_SCALE: assert property (state_ff == ST_SCALE1 && !loadStart &&
		acc_ff[39:21] == '0 |=> result_ff == $past(acc_ff[21:6]))
		else $error("sum not scaled by 1/64");
	AST_SAT_HI: assert property (state_ff == ST_SCALE1 && !acc_ff[39] &&
		!loadStart && acc_ff[38:21] != '0 |=> result_ff == `FXC_OUT_MAX)
		else $error("positive overflow wrapped");
	AST_SAT_LO: assert property (state_ff == ST_SCALE1 && acc_ff[39] &&
		!loadStart && acc_ff[38:21] != '1 |=> result_ff == `FXC_OUT_MIN)
		else $error("negative overflow wrapped");
	AST_ONE_PASS: assert property (state_ff == ST_SCALE1 && !mode2g &&
		!loadStart |=> state_ff == ST_EMIT)
		else $error("extra pass in single filter mode");
	AST_BW_STAGE: assert property (state_ff == ST_SCALE1 && mode2g &&
		!loadStart && yCount_ff >= 6'h3e |=> state_ff == ST_MAC2 ##63
		state_ff == ST_SCALE2)
		else $error("bandwidth stage not run for 63 taps");
	AST_READY_IDLE: assert property (sampleReady |-> state_ff == ST_IDLE &&
		loadDone)
		else $error("sample ready while busy");
endmodule
`default_nettype wire

// ---- tb/fxcor_partner.sv ----
// Sample source and corrected-data consumer facing the filter.
`timescale 1ns/10ps
`default_nettype none
module fxcor_partner (
	input  wire logic       sys_clk,
	input  wire logic       sampleReady,
	input  wire logic       stallMode,
	output logic            sampleValid,
	output logic [7:0]      sampleData,
	output logic [2:0]      sampleFlash,
	output logic            outReady
);
	// ============================================================
	// Source side.
	int seed = 43; // Stall pattern seed, fixed for repeatability.
	initial begin
		sampleValid = 1'b0;
		sampleData  = 8'h00;
		sampleFlash = 3'h0;
		outReady    = 1'b1;
	end
	// Offer one sample with its set index and hold it until taken.
	task automatic send(input logic [7:0] d, input logic [2:0] f);
		#1;
		sampleValid = 1'b1;
		sampleData  = d;
		sampleFlash = f;
		@(posedge sys_clk);
		while (sampleReady !== 1'b1) @(posedge sys_clk);
	endtask
	// Released lines show the inverse, so stale data never looks valid.
	task automatic release_bus();
		#1;
		sampleValid = 1'b0;
		sampleData  = ~sampleData;
		sampleFlash = ~sampleFlash;
	endtask
	// ============================================================
	// Consumer side: stalls about three cycles in four when asked.
	always @(posedge sys_clk) begin
		#1 outReady = stallMode ? ($random(seed) % 4 == 0) : 1'b1;
	end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the flash interleave correction filter.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic               sys_clk = 1'b0;
	logic               rst = 1'b1;
	logic               loadStart = 1'b0;
	logic               coefByteValid = 1'b0;
	logic [7:0]         coefByteData = 8'h00;
	logic               stallMode = 1'b0;
	logic               coefByteReady, sampleValid, sampleReady, outValid;
	logic               outReady, loadDone, loadError;
	logic [7:0]         sampleData;
	logic [2:0]         sampleFlash;
	logic [15:0]        outData;
	int                 seed = 43;
	int                 error_cnt = 0;
	int                 n_checks = 0;
	logic [15:0]        expQ[$];
	logic signed [15:0] cf[9][63];
	int                 hist[$];
	logic [7:0]         bad[3][4] = '{'{8'h00, 8'h80, 8'hff, 8'hff},
		'{8'h00, 8'h00, 8'h03, 8'hff}, '{8'h00, 8'h00, 8'h02, 8'h05}};
	// ============================================================
	// Design and partner.
	fxcor_top u_dut (.sys_clk(sys_clk), .rst(rst), .loadStart(loadStart),
		.coefByteValid(coefByteValid), .coefByteData(coefByteData),
		.coefByteReady(coefByteReady), .sampleValid(sampleValid),
		.sampleData(sampleData), .sampleFlash(sampleFlash),
		.sampleReady(sampleReady), .outValid(outValid), .outData(outData),
		.outReady(outReady), .loadDone(loadDone), .loadError(loadError));
	fxcor_partner u_part (.sys_clk(sys_clk), .sampleReady(sampleReady),
		.stallMode(stallMode), .sampleValid(sampleValid),
		.sampleData(sampleData), .sampleFlash(sampleFlash),
		.outReady(outReady));
	initial forever #12.5 sys_clk = ~sys_clk;
	// ============================================================
	// Checking and closing.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Arithmetic shift then saturation to the signed output range.
	function automatic longint clip(input longint v, input int sh);
		v = v >>> sh;
		return (v > 32767) ? 32767 : ((v < -32768) ? -32768 : v);
	endfunction
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Each word leaving the FIFO is matched with the oldest prediction.
	always @(posedge sys_clk) begin
		if (rst === 1'b0 && outValid === 1'b1 && outReady === 1'b1) begin
			if (expQ.size() == 0) begin
				error_cnt++;
				$display("Error at %0t: unexpected output word", $time);
			end else chk(outData, expQ.pop_front());
		end
	end
	// ============================================================
	// Coefficient block driving.
	task automatic sendByte(input logic [7:0] b);
		#1;
		loadStart     = 1'b0;
		coefByteValid = 1'b1;
		coefByteData  = b;
		@(posedge sys_clk);
		while (coefByteReady !== 1'b1) @(posedge sys_clk);
	endtask
	task automatic startLoad();
		@(posedge sys_clk);
		#1 loadStart = 1'b1;
		@(posedge sys_clk);
		hist.delete();
	endtask
	// Releasing leaves the inverse byte so nothing stale is reused.
	task automatic endBytes();
		#1 coefByteValid = 1'b0;
		coefByteData = ~coefByteData;
		repeat (2) @(posedge sys_clk);
	endtask
	task automatic load(input int s, input int t);
		startLoad();
		sendByte(8'h00);
		sendByte(8'h00);
		sendByte(8'(s));
		sendByte(8'(t));
		for (int i = 0; i < s; i++) begin
			for (int k = 0; k < t; k++) begin
				cf[i][k] = 16'($random(seed));
				sendByte(cf[i][k][7:0]);
				sendByte(cf[i][k][15:8]);
			end
		end
		endBytes();
		chk({14'h0, loadError, loadDone}, 16'h0001);
	endtask
	// ============================================================
	// One mode: load, stream n random samples, predict, drain.
	task automatic run(input int s, input int t, input int n);
		logic [7:0] d;
		logic [2:0] f;
		longint     acc;
		int         fs;
		int         m, st, yh[$];
		load(s, t);
		// Nine sets: 13 flash taps two samples apart, then set 8 on results.
		m = (s == 9) ? 13 : t;
		st = (s == 9) ? 2 : 1;
		for (int j = 0; j < n; j++) begin
			d = 8'($random(seed));
			f = 3'($random(seed));
			fs = int'(f) & ((s == 9) ? 7 : s - 1);
			hist.push_front(int'($signed(d)));
			if (hist.size() > (m - 1) * st) begin
				acc = 0;
				for (int k = 0; k < m; k++) begin
					acc += cf[fs][k] * hist[k * st];
				end
				acc = clip(acc, 6);
				yh.push_front(int'(acc));
				if (s == 9 && yh.size() >= 63) begin
					acc = 0;
					for (int k = 0; k < 63; k++) acc += cf[8][k] * yh[k];
					acc = clip(acc, 14);
				end
				if (s != 9 || yh.size() >= 63) expQ.push_back(16'(acc));
			end
			u_part.send(d, f);
		end
		u_part.release_bus();
		for (int w = 0; w < 3000 && expQ.size() > 0; w++) @(posedge sys_clk);
		chk(16'(expQ.size()), 16'h0000);
	endtask
	// ============================================================
	// Main sequence: refusals first, then four modes, one stalled.
	initial begin
		repeat (2) @(posedge sys_clk);
		#1 rst = 1'b0;
		chk({15'h0, sampleReady}, 16'h0000);
		foreach (bad[i]) begin
			startLoad();
			for (int b = 0; b < 4 && bad[i][b] != 8'hff; b++) sendByte(bad[i][b]);
			endBytes();
			chk({14'h0, loadError, loadDone}, 16'h0002);
		end
		run(1, 2, 12);
		stallMode = 1'b1;
		run(2, 7, 24);
		stallMode = 1'b0;
		run(4, 13, 30);
		run(9, 63, 96);
		end_of_test();
	end
	// A hang counts as a mismatch and ends the run the normal way.
	initial begin
		#400000;
		error_cnt++;
		$display("Error at %0t: watchdog expired", $time);
		end_of_test();
	end
endmodule
`default_nettype wire
